/* File: include/vac_pkg.sv */
package vac_pkg;
  // Register offsets
  localparam logic [7:0] MISC_OFS = 8'h0B;
  localparam logic [7:0] LUMA_LO_OFS = 8'h0C;
  localparam logic [7:0] U_LO_OFS = 8'h0D;
  // Values after reset
  localparam logic [7:0] MISC_RST = 8'h20;
  localparam logic [7:0] LUMA_LO_RST = 8'hD8;
  localparam logic [7:0] U_LO_RST = 8'hFE;
  localparam logic [7:0] V_LO_RST = 8'hB4;
  // Field positions in the options register
  localparam int NOTCH_DISABLE_BIT = 7;
  localparam int COMPONENT_SELECT_BIT = 6;
  localparam int LUMA_DECIM_OFF_BIT = 5;
  localparam int CHROMA_ORDER_INVERT_BIT = 4;
  localparam int LUMA_GAIN_BIT8_BIT = 2;
  localparam int U_GAIN_BIT8_BIT = 1;
  localparam int V_GAIN_BIT8_BIT = 0;
  // Unity gain codes
  localparam int LUMA_UNITY = 216;
  localparam int U_UNITY = 254;
  localparam int V_UNITY = 180;
  // Reciprocals scaled by 2^16, rounded
  localparam int RECIP_SHIFT = 16;
  localparam int LUMA_RECIP = ((1 << RECIP_SHIFT) + LUMA_UNITY / 2) / LUMA_UNITY;
  localparam int U_RECIP = ((1 << RECIP_SHIFT) + U_UNITY / 2) / U_UNITY;
  localparam int V_RECIP = ((1 << RECIP_SHIFT) + V_UNITY / 2) / V_UNITY;
  // Output buffer defaults
  localparam int FIFO_WIDTH = 16;
  localparam int FIFO_DEPTH = 16;
endpackage

/* File: include/vac_strm_if.sv */
`timescale 1ns/10ps
interface vac_strm_if #(
  parameter int WIDTH = 16
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* File: src/vac_gain.sv */
`timescale 1ns/10ps
module vac_gain #(
  parameter bit SIGNED_IN = 1'b0,
  parameter int RECIP = 303
) (
  // Sample and gain
  input wire logic [7:0] sample,
  input wire logic [8:0] gain,
  // Scaled result, saturated
  output logic [7:0] result
);
  localparam logic signed [10:0] RECIP_S = 11'(RECIP);
  localparam logic signed [31:0] ROUND = 32'sh00008000;
  logic signed [9:0] smp_s;
  logic signed [31:0] prod;
  logic signed [15:0] scaled;

  always_comb begin
    smp_s = SIGNED_IN ? {{2{sample[7]}}, sample} : {2'h0, sample};
    prod = 32'(smp_s) * 32'({1'b0, gain}) * 32'(RECIP_S) + ROUND;
    scaled = prod[31:16];
    // Clip rather than wrap: wrap makes bright pixels black
    if (SIGNED_IN) begin
      if (scaled > 16'sh007F) begin
        result = 8'h7F;
      end else if (scaled < -16'sh0080) begin
        result = 8'h80;
      end else begin
        result = scaled[7:0];
      end
    end else begin
      result = (scaled > 16'sh00FF) ? 8'hFF : scaled[7:0];
    end
  end
endmodule

/* File: src/vac_fifo.sv */
`timescale 1ns/10ps
module vac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Fill and drain sides
  vac_strm_if.snk wr,
  vac_strm_if.src rd
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign wr.ready = (cnt_r != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_r != '0);
  assign rd.data = mem_r[rp_r];
  assign push = wr.valid && wr.ready;
  assign pop = rd.valid && rd.ready;

  always_comb begin
    wp_nxt = push ? AW'((wp_r + 1'b1) % DEPTH) : wp_r;
    rp_nxt = pop ? AW'((rp_r + 1'b1) % DEPTH) : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; empty flag guards reads
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wp_r] <= wr.data;
    end
  end

  property p_fifo_no_over;
    @(posedge ref_clk) disable iff (!rst_b)
    cnt_r <= (AW+1)'(DEPTH);
  endproperty
  a_fifo_no_over: assert property (p_fifo_no_over) else $error("fifo count above depth");
endmodule

/* File: src/vac_adjust.sv */
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
module vac_adjust (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Host register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // V gain low byte, held outside this bank
  input wire logic [7:0] v_gain_low_byte,
  // Horizontal delay parity
  input wire logic horizontal_delay_lsb,
  // Input pixels, 4:4:4 with signed chroma
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic pix_sol,
  input wire logic [7:0] pix_y,
  input wire logic [7:0] pix_u,
  input wire logic [7:0] pix_v,
  // Output pixels, 4:2:2 {y, c}
  output logic out_valid,
  input wire logic out_ready,
  output logic out_cr,
  output logic [15:0] out_data,
  // Path status
  output logic notch_en,
  output logic chroma_conv_en,
  output logic decim_en
);
  ////////////////////////////////////////////////////////////////////////////////
  // Register bank
  logic [7:0] misc_r, misc_nxt;
  logic [7:0] luma_lo_r, luma_lo_nxt;
  logic [7:0] u_lo_r, u_lo_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    misc_nxt = misc_r;
    luma_lo_nxt = luma_lo_r;
    u_lo_nxt = u_lo_r;
    rdata_nxt = rdata_r;
    if (reg_wr) begin
      case (reg_addr)
        vac_pkg::MISC_OFS: misc_nxt = reg_wdata;
        vac_pkg::LUMA_LO_OFS: luma_lo_nxt = reg_wdata;
        vac_pkg::U_LO_OFS: u_lo_nxt = reg_wdata;
        default: misc_nxt = misc_r;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        vac_pkg::MISC_OFS: rdata_nxt = misc_r;
        vac_pkg::LUMA_LO_OFS: rdata_nxt = luma_lo_r;
        vac_pkg::U_LO_OFS: rdata_nxt = u_lo_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      misc_r <= vac_pkg::MISC_RST;
      luma_lo_r <= vac_pkg::LUMA_LO_RST;
      u_lo_r <= vac_pkg::U_LO_RST;
      rdata_r <= 8'h00;
    end else begin
      misc_r <= misc_nxt;
      luma_lo_r <= luma_lo_nxt;
      u_lo_r <= u_lo_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoded controls; reserved bit 3 is stored but steers nothing
  logic notch_disable, component_select, luma_decim_off, chroma_order_invert;
  logic [8:0] luma_gain, u_gain, v_gain;

  assign notch_disable = misc_r[vac_pkg::NOTCH_DISABLE_BIT];
  assign component_select = misc_r[vac_pkg::COMPONENT_SELECT_BIT];
  assign luma_decim_off = misc_r[vac_pkg::LUMA_DECIM_OFF_BIT];
  assign chroma_order_invert = misc_r[vac_pkg::CHROMA_ORDER_INVERT_BIT];
  assign luma_gain = {misc_r[vac_pkg::LUMA_GAIN_BIT8_BIT], luma_lo_r};
  assign u_gain = {misc_r[vac_pkg::U_GAIN_BIT8_BIT], u_lo_r};
  assign v_gain = {misc_r[vac_pkg::V_GAIN_BIT8_BIT], v_gain_low_byte};
  assign notch_en = !notch_disable && !component_select;
  assign chroma_conv_en = component_select;
  assign decim_en = !luma_decim_off;

  ////////////////////////////////////////////////////////////////////////////////
  // Luma filters and gains
  logic [7:0] hist1_r, hist1_nxt, hist2_r, hist2_nxt, fprev_r, fprev_nxt;
  logic [8:0] notch_sum, decim_sum;
  logic [7:0] y_notch, y_filt, y_gain, u_gain_out, v_gain_out;
  logic accept;

  always_comb begin
    // Two-tap comb on samples two apart nulls the carrier band
    notch_sum = {1'b0, pix_y} + {1'b0, (pix_sol ? pix_y : hist2_r)};
    y_notch = notch_en ? notch_sum[8:1] : pix_y;
    decim_sum = {1'b0, y_notch} + {1'b0, (pix_sol ? y_notch : fprev_r)};
    y_filt = decim_en ? decim_sum[8:1] : y_notch;
    hist1_nxt = hist1_r;
    hist2_nxt = hist2_r;
    fprev_nxt = fprev_r;
    if (accept) begin
      hist1_nxt = pix_y;
      hist2_nxt = pix_sol ? pix_y : hist1_r;
      fprev_nxt = y_notch;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hist1_r <= 8'h00;
      hist2_r <= 8'h00;
      fprev_r <= 8'h00;
    end else begin
      hist1_r <= hist1_nxt;
      hist2_r <= hist2_nxt;
      fprev_r <= fprev_nxt;
    end
  end

  vac_gain #(.SIGNED_IN(1'b0), .RECIP(vac_pkg::LUMA_RECIP)) u_gain_y (
    .sample(y_filt),
    .gain(luma_gain),
    .result(y_gain)
  );
  vac_gain #(.SIGNED_IN(1'b1), .RECIP(vac_pkg::U_RECIP)) u_gain_u (
    .sample(pix_u),
    .gain(u_gain),
    .result(u_gain_out)
  );
  vac_gain #(.SIGNED_IN(1'b1), .RECIP(vac_pkg::V_RECIP)) u_gain_v (
    .sample(pix_v),
    .gain(v_gain),
    .result(v_gain_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Output stage, chroma order, buffer
  vac_strm_if #(.WIDTH(vac_pkg::FIFO_WIDTH + 1)) fill_if ();
  vac_strm_if #(.WIDTH(vac_pkg::FIFO_WIDTH + 1)) drain_if ();
  logic stg_valid_r, stg_valid_nxt;
  logic [16:0] stg_data_r, stg_data_nxt;
  logic phase_r, phase_nxt;
  logic cur_cr;

  // Stage moves only when the buffer takes it; full buffer stalls input
  assign pix_ready = !stg_valid_r || fill_if.ready;
  assign accept = pix_valid && pix_ready;
  // first pixel Cb when even delay and order not inverted
  assign cur_cr = pix_sol ? (chroma_order_invert ^ horizontal_delay_lsb) : phase_r;

  always_comb begin
    stg_valid_nxt = stg_valid_r;
    stg_data_nxt = stg_data_r;
    phase_nxt = phase_r;
    if (fill_if.ready) begin
      stg_valid_nxt = 1'b0;
    end
    if (accept) begin
      stg_valid_nxt = 1'b1;
      stg_data_nxt = {cur_cr, y_gain, (cur_cr ? v_gain_out : u_gain_out)};
      phase_nxt = !cur_cr;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stg_valid_r <= 1'b0;
      stg_data_r <= 17'h00000;
      phase_r <= 1'b0;
    end else begin
      stg_valid_r <= stg_valid_nxt;
      stg_data_r <= stg_data_nxt;
      phase_r <= phase_nxt;
    end
  end

  assign fill_if.valid = stg_valid_r;
  assign fill_if.data = stg_data_r;
  assign drain_if.ready = out_ready;
  assign out_valid = drain_if.valid;
  assign out_cr = drain_if.data[16];
  assign out_data = drain_if.data[15:0];

  vac_fifo #(.WIDTH(vac_pkg::FIFO_WIDTH + 1), .DEPTH(vac_pkg::FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .wr(fill_if),
    .rd(drain_if)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_misc_write;
    reg_wr && reg_addr == vac_pkg::MISC_OFS;
  endsequence

  sequence s_misc_read;
    reg_rd && !reg_wr && reg_addr == vac_pkg::MISC_OFS;
  endsequence

  property p_misc_reset;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(rst_b) |-> misc_r == vac_pkg::MISC_RST;
  endproperty
  a_misc_reset: assert property (p_misc_reset) else $error("options reset value wrong");

  // Write, idle cycle, read back; the port never stalls
  property p_misc_write;
    @(posedge ref_clk) disable iff (!rst_b)
    s_misc_write ##1 !reg_wr ##1 s_misc_read |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_misc_write: assert property (p_misc_write) else $error("options write not read back");

  property p_notch;
    @(posedge ref_clk) disable iff (!rst_b)
    s_misc_write |=> notch_en == (!$past(reg_wdata[7]) && !$past(reg_wdata[6]));
  endproperty
  a_notch: assert property (p_notch) else $error("notch enable wrong");

  property p_conv;
    @(posedge ref_clk) disable iff (!rst_b)
    s_misc_write |=> chroma_conv_en == $past(reg_wdata[6]);
  endproperty
  a_conv: assert property (p_conv) else $error("converter enable wrong");

  property p_decim;
    @(posedge ref_clk) disable iff (!rst_b)
    s_misc_write |=> decim_en == !$past(reg_wdata[5]);
  endproperty
  a_decim: assert property (p_decim) else $error("decimation select wrong");

  property p_order;
    @(posedge ref_clk) disable iff (!rst_b)
    accept && pix_sol |=> stg_data_r[16] == ($past(chroma_order_invert) ^ $past(horizontal_delay_lsb));
  endproperty
  a_order: assert property (p_order) else $error("first chroma sample wrong");

  property p_luma_gain;
    @(posedge ref_clk) disable iff (!rst_b)
    s_misc_write |=> luma_gain[8] == $past(reg_wdata[2]) && u_gain[8] == $past(reg_wdata[1])
      && v_gain[8] == $past(reg_wdata[0]);
  endproperty
  a_luma_gain: assert property (p_luma_gain) else $error("gain top bits misplaced");

  property p_unity;
    @(posedge ref_clk) disable iff (!rst_b)
    accept && luma_gain == 9'(vac_pkg::LUMA_UNITY) && !notch_en && !decim_en
    |=> stg_data_r[15:8] == $past(pix_y);
  endproperty
  a_unity: assert property (p_unity) else $error("unity luma gain alters sample");

  property p_luma_zero;
    @(posedge ref_clk) disable iff (!rst_b)
    accept && luma_gain == 9'h000 |=> stg_data_r[15:8] == 8'h00;
  endproperty
  a_luma_zero: assert property (p_luma_zero) else $error("zero luma gain not zero");

  property p_u_unity;
    @(posedge ref_clk) disable iff (!rst_b)
    accept && !cur_cr && u_gain == 9'(vac_pkg::U_UNITY) |=> stg_data_r[7:0] == $past(pix_u);
  endproperty
  a_u_unity: assert property (p_u_unity) else $error("unity U gain alters sample");

  property p_luma_lo_rst;
    @(posedge ref_clk) disable iff (!rst_b)
    $rose(rst_b) |-> luma_lo_r == vac_pkg::LUMA_LO_RST && u_lo_r == vac_pkg::U_LO_RST;
  endproperty
  a_luma_lo_rst: assert property (p_luma_lo_rst) else $error("gain byte reset wrong");

  property p_u_write;
    @(posedge ref_clk) disable iff (!rst_b)
    reg_wr && reg_addr == vac_pkg::U_LO_OFS |=> u_gain[7:0] == $past(reg_wdata);
  endproperty
  a_u_write: assert property (p_u_write) else $error("U byte write lost");
endmodule

/* File: sim/video_adjust_control_regs_tb_top.sv */
`timescale 1ns/10ps
module video_adjust_control_regs_tb_top;
  logic ref_clk, rst_b, reg_wr, reg_rd, horizontal_delay_lsb, pix_valid, pix_sol, out_ready;
  logic [7:0] reg_addr, reg_wdata, v_gain_low_byte, pix_y, pix_u, pix_v, reg_rdata;
  logic pix_ready, out_valid, out_cr, notch_en, chroma_conv_en, decim_en;
  logic [15:0] out_data;
  logic hold_out, rd_pend;
  logic [7:0] opt, lg, ug, r1, r2;
  logic [16:0] pq[$];
  logic [7:0] rq[$];
  int fail_count, checked, cycles, seed, phase, i, k;

  vac_adjust dut (.ref_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .v_gain_low_byte,
    .horizontal_delay_lsb, .pix_valid, .pix_ready, .pix_sol, .pix_y, .pix_u, .pix_v, .out_valid, .out_ready,
    .out_cr, .out_data, .notch_en, .chroma_conv_en, .decim_en);

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 0;
    forever #5 ref_clk = ~ref_clk;
  end

  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task conclude;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard, generous over the expected run
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk);
    #1 reg_wr = 0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    #1 reg_rd = 1;
    reg_addr = a;
    rq.push_back(e);
    @(posedge ref_clk);
    #1 reg_rd = 0;
  endtask

  // Read data lands one edge after the strobe; look at mid-cycle
  always @(posedge ref_clk) rd_pend <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_pend) check("reg_rdata", reg_rdata, rq.pop_front());
  end

  // Drain side stalls at random unless the fill test holds it
  always @(posedge ref_clk) begin
    #1 out_ready = !hold_out && ($random(seed) % 4 != 0);
  end

  always @(posedge ref_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      if (pq.size() == 0) check("spare_word", 16'h0001, 16'h0000);
      else begin
        check("out_data", out_data, pq[0][15:0]);
        check("out_cr", out_cr, pq[0][16]);
        void'(pq.pop_front());
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Same rounding as the chosen gain stage, saturated at full scale
  function automatic logic [7:0] ey(input int x, input int g);
    int p;
    p = (x * g * vac_pkg::LUMA_RECIP + 32768) >>> 16;
    return (p > 255) ? 8'hFF : p[7:0];
  endfunction

  task px(input logic [7:0] y, input logic [7:0] u, input logic [7:0] v, input logic sol);
    logic ok;
    logic cr;
    pix_valid = 1;
    pix_y = y;
    pix_u = u;
    pix_v = v;
    pix_sol = sol;
    do begin
      @(negedge ref_clk) ok = pix_ready;
      @(posedge ref_clk);
    end while (ok !== 1'b1);
    #1;
    if (sol) phase = 0;
    cr = phase[0] ^ opt[4] ^ horizontal_delay_lsb;
    pq.push_back({cr, ey(y, {opt[2], lg}),
      cr ? ((v_gain_low_byte == 0 && !opt[0]) ? 8'h00 : v) : ((ug == 0 && !opt[1]) ? 8'h00 : u)});
    phase++;
  endtask

  task drain;
    for (k = 0; k < 300 && pq.size() > 0; k++) @(posedge ref_clk);
    @(posedge ref_clk);
    #1 check("words_left", 16'(pq.size()), 16'h0000);
  endtask

  // Filters bypassed (bits 7 and 5 set) so only the gains shape the data
  task run_line(input logic [7:0] o, input logic [7:0] l, input logic [7:0] u, input logic [7:0] v,
                input logic hd);
    wr(vac_pkg::MISC_OFS, o);
    wr(vac_pkg::LUMA_LO_OFS, l);
    wr(vac_pkg::U_LO_OFS, u);
    opt = o;
    lg = l;
    ug = u;
    v_gain_low_byte = v;
    horizontal_delay_lsb = hd;
    r1 = 8'($random(seed));
    r2 = 8'($random(seed));
    for (i = 0; i < 9; i++) px(8'($random(seed)), r1, r2, i == 0);
    pix_valid = 0;
    pix_sol = 0;
    drain;
    $display("test line %h %h %h done", o, l, u);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 64;
    {rst_b, reg_wr, reg_rd, pix_valid, pix_sol, out_ready, hold_out, horizontal_delay_lsb} = '0;
    {reg_addr, reg_wdata, pix_y, pix_u, pix_v} = '0;
    v_gain_low_byte = vac_pkg::V_LO_RST;
    repeat (10) @(posedge ref_clk);
    #1 rst_b = 1;
    check("notch_en", notch_en, 1'b1);
    check("chroma_conv_en", chroma_conv_en, 1'b0);
    check("decim_en", decim_en, 1'b0);
    rd(vac_pkg::MISC_OFS, 8'h20);
    rd(vac_pkg::LUMA_LO_OFS, 8'hD8);
    rd(vac_pkg::U_LO_OFS, 8'hFE);
    $display("test reset done");
    for (int m = 0; m < 8; m++) begin
      r1 = 8'($random(seed));
      opt = {m[2:0], r1[4], 1'b0, r1[2:0]};
      wr(vac_pkg::MISC_OFS, opt);
      rd(vac_pkg::MISC_OFS, opt);
      check("notch_en", notch_en, !opt[7] && !opt[6]);
      check("chroma_conv_en", chroma_conv_en, opt[6]);
      check("decim_en", decim_en, !opt[5]);
    end
    $display("test modes done");
    r1 = 8'($random(seed));
    r2 = 8'($random(seed));
    wr(vac_pkg::LUMA_LO_OFS, r1);
    wr(vac_pkg::U_LO_OFS, r2);
    wr(8'h0E, 8'h5A);
    rd(vac_pkg::LUMA_LO_OFS, r1);
    rd(vac_pkg::U_LO_OFS, r2);
    rd(8'h0E, 8'h00);
    rd(vac_pkg::LUMA_LO_OFS, r1);
    rd(vac_pkg::MISC_OFS, opt);
    opt = reg_rdata ^ 8'h07;
    wr(vac_pkg::MISC_OFS, opt);
    rd(vac_pkg::MISC_OFS, opt);
    $display("test registers done");
    // unity, double, zero and top gains
    // U and V at default gain, except zero U in the second line and zero V in the third
    run_line(8'hE0, 8'hD8, 8'hFE, vac_pkg::V_LO_RST, 1'b0);
    run_line(8'hF4, 8'hB0, 8'h00, vac_pkg::V_LO_RST, 1'b0);
    run_line(8'hF0, 8'h00, 8'hFE, 8'h00, 1'b1);
    run_line(8'hE4, 8'hFF, 8'hFE, vac_pkg::V_LO_RST, 1'b1);
    // Output held off: buffer plus stage must fill, then drain
    hold_out = 1;
    repeat (2) @(posedge ref_clk);
    #1;
    for (i = 0; i < 40 && pix_ready === 1'b1; i++) px(8'($random(seed)), r1, r2, i == 0);
    pix_valid = 0;
    check("accepted", 16'(i), 16'd17);
    hold_out = 0;
    drain;
    $display("test fill done");
    // notch and decimation on; flat luma must pass unchanged
    wr(vac_pkg::MISC_OFS, 8'h00);
    wr(vac_pkg::LUMA_LO_OFS, vac_pkg::LUMA_LO_RST);
    opt = 8'h00;
    lg = vac_pkg::LUMA_LO_RST;
    r2 = 8'($random(seed));
    for (i = 0; i < 9; i++) px(r2, r1, r1, i == 0);
    pix_valid = 0;
    pix_sol = 0;
    drain;
    $display("test filters done");
    conclude;
  end
endmodule
